//--- rtl/ddc_chan_pkg.sv
// shared constants and carriers for one converter channel front end:
// nco option control, hop hold-off and the resampling cic stage.
// assumes one channel clock and a simple microport with 8-bit addresses.
//
// Contract
// - amplitude dither bit 2 enables amplitude error randomising in nco conversion
// - amplitude and phase dither are enabled independently of each other
// - bit 3 high clears phase accumulator at start of next frequency change
// - clearing never touches phase offset; bit 3 low keeps phase continuous
// - bit 6 one selects input port b, zero selects input port a
// - bits 8:7 select sync pin: 00 a, 01 b, 10 c, 11 d
// - any pin may serve many channels; channel follows exactly one pin
// - interpolation 1..512, decimation 1..4096; software keeps l/m at most one
// - resample by zero stuffing by l then second-order cic decimating by m
// - accept input at full port rate, output at l times rate over m
// - attenuate by 5-bit shift in 6 db steps and divide gain by l
// - ratio 1/1 bypasses the filter but scaling still applies
// - decimation register holds m-1, interpolation register holds l-1
// - no faster clock; filter response depends only on ratio l/m
// - hop or sleep exit loads 16-bit hold-off; update at one, zero blocks
// - bits 9:5 apply while level indicator inactive, bits 4:0 while active
package ddc_chan_pkg;

    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 16;
    localparam int          IN_W         = 12;
    localparam int          DEC_W        = 12;
    localparam int          INTP_W       = 9;
    localparam int          SHIFT_W      = 5;
    localparam int          HOLD_W       = 16;
    localparam int          SYNC_PINS    = 4;

    localparam logic [7:0]  HOLDOFF_ADDR = 8'h84;
    localparam logic [7:0]  CTRL_ADDR    = 8'h88;
    localparam logic [7:0]  DEC_ADDR     = 8'h90;
    localparam logic [7:0]  INTP_ADDR    = 8'h91;
    localparam logic [7:0]  SCALE_ADDR   = 8'h92;

    localparam logic [15:0] HOLDOFF_RST  = 16'h0000;
    localparam logic [8:0]  CTRL_RST     = 9'h000;
    localparam logic [11:0] DEC_RST      = 12'h000;
    localparam logic [8:0]  INTP_RST     = 9'h000;
    localparam logic [11:0] SCALE_RST    = 12'h000;

    typedef struct packed {
        logic [1:0] sync_sel;
        logic       in_sel_b;
        logic [1:0] rsvd;
        logic       clr_on_hop;
        logic       amp_dither;
        logic       phase_dither;
        logic       nco_bypass;
    } nco_ctrl_s;

    typedef struct packed {
        logic [1:0]         rsvd;
        logic [SHIFT_W-1:0] scale_when_indicator_inactive;
        logic [SHIFT_W-1:0] scale_when_indicator_active;
    } scale_s;

endpackage

//--- rtl/ddc_channel_front.sv
// one channel front end: nco option bits, hop hold-off, input select,
// scaling and the second-order resampling cic stage with output fifo.
// assumes converter ports and level indicator arrive from outside the
// clock domain; sleep and the microport are on the channel clock.
`timescale 1ns/1ps
module ddc_channel_front #(
    parameter int ACC_W   = 40,
    parameter int OUT_W   = 24,
    parameter int FIFO_D  = 8
) (
    input  wire logic                           sys_clk_i,
    input  wire logic                           srst_i,
    input  wire logic [ddc_chan_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [ddc_chan_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                           reg_wr_i,
    input  wire logic                           reg_rd_i,
    output logic      [ddc_chan_pkg::DATA_W-1:0] reg_rdata_o,
    input  wire logic [ddc_chan_pkg::IN_W-1:0]   port_a_i,
    input  wire logic [ddc_chan_pkg::IN_W-1:0]   port_b_i,
    input  wire logic                           level_indicator_i,
    input  wire logic                           ext_sync_pin_a_i,
    input  wire logic                           ext_sync_pin_b_i,
    input  wire logic                           ext_sync_pin_c_i,
    input  wire logic                           ext_sync_pin_d_i,
    input  wire logic                           channel_sleep_i,
    output logic                                nco_bypass_o,
    output logic                                nco_phase_dither_o,
    output logic                                nco_amp_dither_o,
    output logic                                nco_freq_load_o,
    output logic                                nco_phase_clear_o,
    output logic      [OUT_W-1:0]               out_data_o,
    output logic                                out_valid_o,
    input  wire logic                           out_ready_i
);
    localparam int IW = ddc_chan_pkg::IN_W;

    ddc_chan_pkg::nco_ctrl_s ctrl_reg;
    ddc_chan_pkg::scale_s    scale_reg;
    logic [11:0]             dec_reg;
    logic [8:0]              intp_reg;
    logic [15:0]             holdoff_reg;
    logic [15:0]             hold_cnt_reg;
    logic [4:0]              pin_meta_reg;
    logic [4:0]              pin_sync_reg;
    logic [IW-1:0]           a_meta_reg;
    logic [IW-1:0]           a_sync_reg;
    logic [IW-1:0]           b_meta_reg;
    logic [IW-1:0]           b_sync_reg;
    logic                    sel_pin_prev_reg;
    logic                    sleep_prev_reg;
    logic                    sel_pin;
    logic                    load_evt;
    logic [IW-1:0]           x_sel;
    logic [4:0]              shift_sel;
    logic [ACC_W-1:0]        x_scaled_reg;
    logic                    s1_valid_reg;
    logic [12:0]             m_val;
    logic [12:0]             l_val;
    logic                    bypass;
    logic [12:0]             phase_reg;
    logic [12:0]             phase_sum;
    logic                    hit;
    logic [ACC_W-1:0]        i1_reg;
    logic [ACC_W-1:0]        i2_reg;
    logic [ACC_W-1:0]        i1_next;
    logic [ACC_W-1:0]        dec_val_reg;
    logic                    dec_valid_reg;
    logic [ACC_W-1:0]        c1_d_reg;
    logic [ACC_W-1:0]        v_d_reg;
    logic [ACC_W-1:0]        c1;
    logic [ACC_W-1:0]        c2;
    logic [ACC_W-1:0]        push_data_reg;
    logic                    push_valid_reg;
    logic                    fifo_ready;
    logic                    stall;
    logic                    ratio_wr;

    function automatic logic [ACC_W-1:0] mul_k(input logic [ACC_W-1:0] v, input logic [12:0] k);
        logic [ACC_W+12:0] p;
        p = v * {{(ACC_W-13){1'b0}}, k};
        return p[ACC_W-1:0];
    endfunction

    // -------------------------------------------------------------------
    // microport registers
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ctrl_reg    <= ddc_chan_pkg::CTRL_RST;
            dec_reg     <= ddc_chan_pkg::DEC_RST;
            intp_reg    <= ddc_chan_pkg::INTP_RST;
            scale_reg   <= ddc_chan_pkg::SCALE_RST;
            holdoff_reg <= ddc_chan_pkg::HOLDOFF_RST;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ddc_chan_pkg::CTRL_ADDR: begin
                    ctrl_reg      <= reg_wdata_i[8:0];
                    ctrl_reg.rsvd <= 2'h0;
                end
                ddc_chan_pkg::DEC_ADDR:     dec_reg     <= reg_wdata_i[11:0];
                ddc_chan_pkg::INTP_ADDR:    intp_reg    <= reg_wdata_i[8:0];
                ddc_chan_pkg::SCALE_ADDR:   scale_reg   <= {2'h0, reg_wdata_i[9:0]};
                ddc_chan_pkg::HOLDOFF_ADDR: holdoff_reg <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // reads answer one cycle later; unmapped reads give zero
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                ddc_chan_pkg::CTRL_ADDR:    reg_rdata_o <= {7'h00, ctrl_reg};
                ddc_chan_pkg::DEC_ADDR:     reg_rdata_o <= {4'h0, dec_reg};
                ddc_chan_pkg::INTP_ADDR:    reg_rdata_o <= {7'h00, intp_reg};
                ddc_chan_pkg::SCALE_ADDR:   reg_rdata_o <= {4'h0, scale_reg};
                ddc_chan_pkg::HOLDOFF_ADDR: reg_rdata_o <= hold_cnt_reg;
                default:                    reg_rdata_o <= 16'h0000;
            endcase
        end
    end

    assign nco_bypass_o       = ctrl_reg.nco_bypass;
    assign nco_phase_dither_o = ctrl_reg.phase_dither;
    assign nco_amp_dither_o   = ctrl_reg.amp_dither;

    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
            a_meta_reg   <= '0;
            a_sync_reg   <= '0;
            b_meta_reg   <= '0;
            b_sync_reg   <= '0;
        end else begin
            pin_meta_reg <= {level_indicator_i, ext_sync_pin_d_i, ext_sync_pin_c_i,
                             ext_sync_pin_b_i, ext_sync_pin_a_i};
            pin_sync_reg <= pin_meta_reg;
            a_meta_reg   <= port_a_i;
            a_sync_reg   <= a_meta_reg;
            b_meta_reg   <= port_b_i;
            b_sync_reg   <= b_meta_reg;
        end
    end

    // -------------------------------------------------------------------
    // hop detection and hold-off
    // -------------------------------------------------------------------
    assign sel_pin  = pin_sync_reg[ctrl_reg.sync_sel];
    assign load_evt = (sel_pin && !sel_pin_prev_reg) || (sleep_prev_reg && !channel_sleep_i);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sel_pin_prev_reg  <= 1'b0;
            sleep_prev_reg    <= 1'b0;
            hold_cnt_reg      <= 16'h0000;
            nco_freq_load_o   <= 1'b0;
            nco_phase_clear_o <= 1'b0;
        end else begin
            sel_pin_prev_reg  <= sel_pin;
            sleep_prev_reg    <= channel_sleep_i;
            nco_freq_load_o   <= 1'b0;
            nco_phase_clear_o <= 1'b0;
            if (load_evt) begin
                hold_cnt_reg <= holdoff_reg;  // zero never reaches one
            end else if (hold_cnt_reg > 16'h0001) begin
                hold_cnt_reg <= hold_cnt_reg - 16'h0001;
            end else if (hold_cnt_reg == 16'h0001) begin
                hold_cnt_reg      <= 16'h0000;
                nco_freq_load_o   <= 1'b1;
                nco_phase_clear_o <= ctrl_reg.clr_on_hop;
            end
        end
    end

    // -------------------------------------------------------------------
    // input select and scaling
    // -------------------------------------------------------------------
    assign x_sel     = ctrl_reg.in_sel_b ? b_sync_reg : a_sync_reg;
    assign shift_sel = pin_sync_reg[4] ? scale_reg.scale_when_indicator_active
                                       : scale_reg.scale_when_indicator_inactive;
    assign m_val     = {1'b0, dec_reg} + 13'h0001;
    assign l_val     = {4'h0, intp_reg} + 13'h0001;
    assign bypass    = (dec_reg == 12'h000) && (intp_reg == 9'h000);
    assign stall     = push_valid_reg && !fifo_ready;
    assign ratio_wr  = reg_wr_i && (reg_addr_i == ddc_chan_pkg::DEC_ADDR ||
                                    reg_addr_i == ddc_chan_pkg::INTP_ADDR);

    // scaling sits ahead of the filter so bypass still attenuates
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            x_scaled_reg <= '0;
            s1_valid_reg <= 1'b0;
        end else if (!stall) begin
            x_scaled_reg <= $signed({{(ACC_W-2*IW){x_sel[IW-1]}}, x_sel, {IW{1'b0}}}) >>> shift_sel;
            s1_valid_reg <= 1'b1;  // one sample each clock
        end
    end

    // -------------------------------------------------------------------
    // zero-stuffed integrators, all l phases folded into one clock
    // -------------------------------------------------------------------
    assign phase_sum = phase_reg + l_val;
    assign hit       = (phase_sum >= m_val);
    assign i1_next   = i1_reg + x_scaled_reg;

    // a limitation: with l above m only one of several outputs survives
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            phase_reg     <= 13'h0000;
            i1_reg        <= '0;
            i2_reg        <= '0;
            dec_val_reg   <= '0;
            dec_valid_reg <= 1'b0;
        end else if (ratio_wr) begin
            // new ratio restarts the phase so it stays below m; one sample lost
            phase_reg     <= 13'h0000;
            dec_valid_reg <= 1'b0;
        end else if (!stall) begin
            dec_valid_reg <= 1'b0;
            if (s1_valid_reg && !bypass) begin
                i1_reg    <= i1_next;
                i2_reg    <= i2_reg + mul_k(i1_next, l_val);
                phase_reg <= hit ? phase_sum - m_val : phase_sum;
                if (hit) begin
                    dec_val_reg   <= i2_reg + mul_k(i1_next, m_val - phase_reg);
                    dec_valid_reg <= 1'b1;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // combs, division by l, push into fifo
    // -------------------------------------------------------------------
    assign c1 = dec_val_reg - v_d_reg;
    assign c2 = c1 - c1_d_reg;

    // the divider is wide and slow; traded for exact gain over any l
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            v_d_reg        <= '0;
            c1_d_reg       <= '0;
            push_data_reg  <= '0;
            push_valid_reg <= 1'b0;
        end else if (!stall) begin
            push_valid_reg <= 1'b0;
            if (bypass && s1_valid_reg) begin
                push_data_reg  <= x_scaled_reg;
                push_valid_reg <= 1'b1;
            end else if (dec_valid_reg) begin
                v_d_reg        <= dec_val_reg;
                c1_d_reg       <= c1;
                push_data_reg  <= ACC_W'($signed(c2) / $signed({1'b0, l_val}));
                push_valid_reg <= 1'b1;
            end
        end
    end

    sample_fifo #(
        .WIDTH (OUT_W),
        .DEPTH (FIFO_D)
    ) u_out_fifo (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .in_data_i   (push_data_reg[OUT_W-1:0]),
        .in_valid_i  (push_valid_reg),
        .in_ready_o  (fifo_ready),
        .out_data_o  (out_data_o),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i)
    );

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    amp_dither_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        reg_wr_i && reg_addr_i == ddc_chan_pkg::CTRL_ADDR |=> nco_amp_dither_o == $past(reg_wdata_i[2]))
        else $error("amplitude dither not following control write");
    dither_indep_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        reg_wr_i && reg_addr_i == ddc_chan_pkg::CTRL_ADDR |=>
        {nco_amp_dither_o, nco_phase_dither_o} == $past(reg_wdata_i[2:1]))
        else $error("dither bits not independent");
    clear_hop_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        nco_phase_clear_o |-> nco_freq_load_o && $past(ctrl_reg.clr_on_hop))
        else $error("phase clear outside a frequency change");
    phase_cont_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        $rose(nco_freq_load_o) && !$past(ctrl_reg.clr_on_hop) |-> !nco_phase_clear_o)
        else $error("phase cleared with clear bit low");
    input_sel_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        ctrl_reg.in_sel_b && !stall && $stable(ctrl_reg) |-> x_sel == b_sync_reg)
        else $error("port b not selected");
    sync_pick_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        ctrl_reg.sync_sel == 2'h2 && !channel_sleep_i && !sleep_prev_reg |->
        load_evt == (pin_sync_reg[2] && !sel_pin_prev_reg))
        else $error("wrong sync pin drives hop");
    holdoff_one_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        load_evt && holdoff_reg == 16'h0001 |-> ##2 nco_freq_load_o)
        else $error("hold-off of one did not update at once");
    holdoff_zero_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        load_evt && holdoff_reg == 16'h0000 |=> !nco_freq_load_o ##1 !nco_freq_load_o)
        else $error("hold-off of zero let an update through");
    phase_range_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        intp_reg <= dec_reg && $stable(dec_reg) && $stable(intp_reg) |=> phase_reg < m_val)
        else $error("resampler phase out of range");
    bypass_pass_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        bypass && s1_valid_reg && !stall |=> push_valid_reg && push_data_reg == $past(x_scaled_reg))
        else $error("bypass sample lost or unscaled");

    hop_clear_c:   cover property (@(posedge sys_clk_i) disable iff (srst_i) nco_phase_clear_o);
    resample_c:    cover property (@(posedge sys_clk_i) disable iff (srst_i) dec_valid_reg && !bypass);
    fifo_full_c:   cover property (@(posedge sys_clk_i) disable iff (srst_i) stall);

endmodule

//--- rtl/sample_fifo.sv
// small synchronous fifo between the resampler and the next stage.
// assumes both sides on one clock; outputs come from flip-flops.
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW-1:0]    rd_ptr_next;
    logic [PW:0]      count_reg;
    logic [PW:0]      count_next;
    logic             push;
    logic             pop;

    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign count_next  = count_reg + (PW+1)'(push) - (PW+1)'(pop);
    assign rd_ptr_next = !pop ? rd_ptr_reg : (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + PW'(1);

    // -------------------------------------------------------------------
    // storage and head
    // -------------------------------------------------------------------
    // head kept in a flop so the output never sees the memory mux
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
        if (push && wr_ptr_reg == rd_ptr_next) begin
            out_data_o <= in_data_i;
        end else begin
            out_data_o <= mem_reg[rd_ptr_next];
        end
    end

    // -------------------------------------------------------------------
    // pointers and flags
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wr_ptr_reg  <= '0;
            rd_ptr_reg  <= '0;
            count_reg   <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + PW'(1);
            end
            rd_ptr_reg  <= rd_ptr_next;
            count_reg   <= count_next;
            in_ready_o  <= (count_next != (PW+1)'(DEPTH));
            out_valid_o <= (count_next != '0);
        end
    end

endmodule

//--- verif/conv_sink_model.sv
// partner: converter ports feeding the channel and the stage after it.
// assumes the bench picks samples and stall pattern; one clock.
`timescale 1ns/1ps
module conv_sink_model (
    input  wire logic        sys_clk_i,
    input  wire logic [11:0] samp_a_i,
    input  wire logic [11:0] samp_b_i,
    input  wire logic        stall_i,
    input  wire logic        out_valid_i,
    input  wire logic [23:0] out_data_i,
    output logic      [11:0] port_a_o,
    output logic      [11:0] port_b_o,
    output logic             out_ready_o,
    output int               got_o,
    output logic      [23:0] last_o
);
    assign port_a_o = samp_a_i;
    assign port_b_o = samp_b_i;
    // stalls back up the fifo, so no input is trusted during them
    assign out_ready_o = !stall_i;
    initial got_o = 0;
    always @(posedge sys_clk_i) begin
        if (out_valid_i && out_ready_o) begin
            got_o <= got_o + 1;
            last_o <= out_data_i;
        end
    end
endmodule

//--- verif/ddc_channel_front_tb.sv
// bench for the channel front: registers, hops, resampler and fifo.
// assumes the partner model drives ports and drains output.
`timescale 1ns/1ps
module ddc_channel_front_tb;
    logic        sys_clk_i, srst_i, reg_wr_i, reg_rd_i, lvl, sleep, stall;
    logic        byp, pdi, adi, fl, pc, ov, ordy;
    logic [7:0]  reg_addr_i;
    logic [15:0] reg_rdata_o, reg_wdata_i;
    logic [11:0] sa, sb, pa, pb;
    logic [3:0]  pins;
    logic [23:0] od, last;
    int          miscompares, tests_run, got, seed, n, c, t0, t1, x, e, y;
    logic        chk_on;
    logic [7:0]  ra[5] = '{8'h88, 8'h90, 8'h91, 8'h92, 8'h55};
    logic [15:0] re[5] = '{16'h01CF, 16'h0FFF, 16'h01FF, 16'h03FF, 16'h0000};
    int          tl[5] = '{1, 1, 1, 2, 1};
    int          tm[5] = '{1, 1, 4, 8, 2};
    int          ts[5] = '{0, 3, 4, 4, 2};

    ddc_channel_front u_ddc_channel_front (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .port_a_i(pa), .port_b_i(pb), .level_indicator_i(lvl), .ext_sync_pin_a_i(pins[0]),
        .ext_sync_pin_b_i(pins[1]), .ext_sync_pin_c_i(pins[2]), .ext_sync_pin_d_i(pins[3]),
        .channel_sleep_i(sleep), .nco_bypass_o(byp), .nco_phase_dither_o(pdi), .nco_amp_dither_o(adi),
        .nco_freq_load_o(fl), .nco_phase_clear_o(pc), .out_data_o(od), .out_valid_o(ov), .out_ready_i(ordy));
    conv_sink_model u_conv_sink_model (.sys_clk_i(sys_clk_i), .samp_a_i(sa), .samp_b_i(sb), .stall_i(stall),
        .out_valid_i(ov), .out_data_i(od), .port_a_o(pa), .port_b_o(pb), .out_ready_o(ordy), .got_o(got),
        .last_o(last));

    // every sample handed over while chk_on is set must equal the model level y
    always @(posedge sys_clk_i) begin
        if (chk_on && ov && ordy) begin
            tests_run++;
            if (od !== 24'(y)) begin
                miscompares++;
                $display("[FAIL] %0t stream got %h exp %h", $time, od, 24'(y));
            end
        end
    end

    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = !sys_clk_i;
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic chk(input logic [23:0] g, input logic [23:0] x0, input string m);
        tests_run++;
        if (g !== x0) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, x0);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        cyc(1);
        reg_wr_i = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] x0);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        cyc(1);
        reg_rd_i = 1'b0;
        cyc(1);
        chk(24'(reg_rdata_o), 24'(x0), "read");
    endtask
    // p below 4 raises that pin, 4 is a sleep exit
    task automatic hop(input int p, input int en, input int ec);
        n = 0;
        c = 0;
        t0 = -1;
        if (p < 4) pins[p] = 1'b1; // pin taken as enabled at chip level
        else sleep = 1'b0;
        for (int i = 0; i < 24; i++) begin
            cyc(1);
            if (fl === 1'b1 && t0 < 0) t0 = i;
            n += (fl === 1'b1);
            c += (fl === 1'b1 && pc === 1'b1);
        end
        pins = 4'h0;
        chk(24'(n), 24'(en), "freq loads");
        chk(24'(c), 24'(ec), "phase clears");
        cyc(4);
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        {srst_i, reg_wr_i, reg_rd_i, lvl, sleep, stall} = 6'h20;
        chk_on = 1'b0;
        {reg_addr_i, reg_wdata_i, sa, sb, pins} = '0;
        {miscompares, tests_run} = '0;
        seed = 32'h4B58;
        cyc(4);
        srst_i = 1'b0;
        foreach (ra[i]) rd(ra[i], 16'h0000);
        foreach (ra[i]) begin
            wr(ra[i], 16'hFFFF);
            rd(ra[i], re[i]);
        end
        for (int k = 0; k < 8; k++) begin
            wr(8'h88, 16'(k));
            chk({21'h0, adi, pdi, byp}, 24'(k), "options");
        end
        $display("registers and options done");
        wr(8'h84, 16'h0001);
        for (int s = 0; s < 4; s++) begin
            wr(8'h88, 16'((s << 7) | 8));
            hop((s + 1) % 4, 0, 0);
            hop(s, 1, 1);
        end
        wr(8'h88, 16'h0000);
        hop(0, 1, 0);
        t1 = t0;
        wr(8'h84, 16'h0005);
        hop(0, 1, 0);
        chk(24'(t0), 24'(t1 + 4), "hold-off delay");
        sleep = 1'b1;
        cyc(2);
        hop(4, 1, 0);
        wr(8'h84, 16'h0000);
        hop(0, 0, 0);
        $display("hops done");
        // expected level: x shifted up by 12, down by s, times m squared over l squared
        foreach (tl[i]) begin
            sa = 12'($random(seed));
            sb = 12'($random(seed));
            x = (i % 2) ? $signed(sb) : $signed(sa);
            wr(8'h90, 16'(tm[i] - 1));
            wr(8'h91, 16'(tl[i] - 1));
            wr(8'h92, 16'((ts[i] << 5) | ts[i]));
            wr(8'h88, 16'((i % 2) << 6));
            y = ((x * 4096) >>> ts[i]) * tm[i] * tm[i] / (tl[i] * tl[i]);
            cyc(80);
            n = got;
            chk_on = 1'b1;
            cyc(240);
            chk_on = 1'b0;
            e = 240 * tl[i] / tm[i];
            chk(last, 24'(y), "sample");
            chk(24'(got - n >= e - 1 && got - n <= e + 1), 24'h000001, "rate");
        end
        $display("resampler done");
        wr(8'h90, 16'h0000);
        wr(8'h92, 16'h0002);
        lvl = 1'b1;
        cyc(80);
        chk(last, 24'((x * 4096) >>> 2), "active scale");
        lvl = 1'b0;
        cyc(80);
        chk(last, 24'(x * 4096), "inactive scale");
        y = x * 4096;
        chk_on = 1'b1;
        stall = 1'b1;
        n = got;
        cyc(40);
        chk({23'h0, ov}, 24'h000001, "held");
        chk(24'(got), 24'(n), "no moves");
        for (int i = 0; i < 100; i++) begin
            stall = 1'($random(seed));
            cyc(1);
        end
        stall = 1'b0;
        cyc(40);
        chk_on = 1'b0;
        chk(last, 24'(x * 4096), "after stalls");
        $display("fifo done");
        stop_test();
    end
endmodule
